// ### hdl/sgrc_top.sv
// sleep gating and reset control: sleep gating of the comparator and, in power-down
// and power-save, the main clock; input buffer gating, scan port, reset stretching
// assumes all inputs are synchronous to CLOCK_IN at 10 MHz
`timescale 1ns/10ps

module sgrc_top #(
	parameter int NUM_PINS = 8,
	parameter logic [19:0] TOUT_CYC0 = 20'h00010,
	parameter logic [19:0] TOUT_CYC1 = 20'h00080,
	parameter logic [19:0] TOUT_CYC2 = 20'h00400,
	parameter logic [19:0] TOUT_CYC3 = 20'h02000
) (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic SLEEP_IN,
	input wire sgrc_pkg::sgrc_sleep_mode_t SLEEP_MODE_IN,
	input wire logic ADC_EN_IN,
	input wire logic CONV_START_IN,
	input wire logic ACMP_EN_IN,
	input wire logic ACMP_USE_REF_IN,
	input wire logic [1:0] BROWN_OUT_LEVEL_FUSES_IN,
	input wire logic WDT_EN_IN,
	input wire logic WDT_EXPIRE_IN,
	input wire logic [NUM_PINS-1:0] WAKE_PIN_NEED_IN,
	input wire logic DEBUG_ENABLE_FUSE_IN,
	input wire logic SCAN_PORT_ENABLE_FUSE_IN,
	input wire logic SCAN_PORT_DISABLE_BIT_IN,
	input wire logic TAP_SHIFT_IN,
	input wire logic TDO_DATA_IN,
	input wire logic POWER_ON_RST_IN,
	input wire logic EXT_RST_N_IN,
	input wire logic BROWN_OUT_DET_IN,
	input wire logic SCAN_RST_REG_IN,
	input wire logic [sgrc_pkg::SGRC_SUT_W-1:0] STARTUP_TIME_FUSES_IN,
	input wire logic [sgrc_pkg::SGRC_CLOCK_SELECT_FUSES_W-1:0] CLOCK_SELECT_FUSES_IN,
	output logic ADC_POWER_OUT,
	output logic ADC_EXTENDED_OUT,
	output logic ACMP_POWER_OUT,
	output logic VREF_POWER_OUT,
	output logic BOD_ACTIVE_OUT,
	output logic WDT_RUN_OUT,
	output logic [NUM_PINS-1:0] INPUT_BUF_EN_OUT,
	output logic MAIN_CLK_RUN_OUT,
	output logic SCAN_PORT_ACTIVE_OUT,
	output logic TDO_OUT,
	output logic TDO_OE_N_OUT,
	output logic PORT_RESET_OUT,
	output logic CORE_RESET_OUT,
	output logic IO_REG_INIT_OUT,
	output logic START_AT_VECTOR_OUT,
	output sgrc_pkg::sgrc_rst_src_t RESET_CAUSE_OUT
);
	import sgrc_pkg::*;

	// ----------------------------------------------------------------
	// sleep mode decode
	// ----------------------------------------------------------------
	// idle keeps the I/O clock; idle and noise reduction keep adc clock
	wire light_sleep = (SLEEP_MODE_IN == SGRC_IDLE) ||
		(SLEEP_MODE_IN == SGRC_ADC_NR);
	wire deep_sleep = SLEEP_IN && !light_sleep;
	wire clocks_stopped = SLEEP_IN && ((SLEEP_MODE_IN == SGRC_POWER_DOWN) ||
		(SLEEP_MODE_IN == SGRC_POWER_SAVE) ||
		(SLEEP_MODE_IN == SGRC_STANDBY));
	wire main_clk_stop = SLEEP_IN && ((SLEEP_MODE_IN == SGRC_POWER_DOWN) ||
		(SLEEP_MODE_IN == SGRC_POWER_SAVE));

	// ----------------------------------------------------------------
	// analog module gating
	// ----------------------------------------------------------------
	// converter power ignores sleep: software must switch it off itself
	wire next_adc_power = ADC_EN_IN;
	wire adc_power_up = next_adc_power && !ADC_POWER_OUT;
	// set wins over clear so a restart during a conversion start is kept
	wire next_adc_ext = adc_power_up ? 1'b1 :
		(CONV_START_IN ? 1'b0 : ADC_EXTENDED_OUT);
	wire next_acmp_power = ACMP_EN_IN && !deep_sleep;
	wire acmp_ref_need = ACMP_EN_IN && ACMP_USE_REF_IN;
	wire bod_on = (BROWN_OUT_LEVEL_FUSES_IN != SGRC_BOD_OFF_CODE);
	// reference users are sampled without regard to sleep state
	wire next_vref = bod_on || acmp_ref_need || ADC_EN_IN;
	wire next_wdt_run = WDT_EN_IN;

	// ----------------------------------------------------------------
	// pin input buffers and main clock
	// ----------------------------------------------------------------
	// wake-up pins override the stop so their edges are still seen
	wire [NUM_PINS-1:0] next_buf_en = clocks_stopped ?
		WAKE_PIN_NEED_IN : {NUM_PINS{1'b1}};
	wire scan_active = SCAN_PORT_ENABLE_FUSE_IN &&
		!SCAN_PORT_DISABLE_BIT_IN;
	// debug needs the clock even in deep sleep; costs standby current
	wire dbg_keep_clk = DEBUG_ENABLE_FUSE_IN && scan_active;
	wire next_main_clk = !main_clk_stop || dbg_keep_clk;

	// ----------------------------------------------------------------
	// scan data-out pin
	// ----------------------------------------------------------------
	// pin floats unless shifting, so the board needs a pull-up
	wire next_tdo_oe_n = !(scan_active && TAP_SHIFT_IN);
	wire next_tdo = scan_active && TAP_SHIFT_IN && TDO_DATA_IN;

	// ----------------------------------------------------------------
	// reset source collection
	// ----------------------------------------------------------------
	sgrc_rst_src_t src;
	assign src.power_on = POWER_ON_RST_IN;
	assign src.external = !EXT_RST_N_IN;
	assign src.watchdog = WDT_EN_IN && WDT_EXPIRE_IN;
	assign src.brown_out = bod_on && BROWN_OUT_DET_IN;
	assign src.scan_reg = SCAN_RST_REG_IN;
	wire any_src = |src;

	// ports must fall back without a clock, so this path is combinational
	assign PORT_RESET_OUT = any_src || RST_IN;

	// ----------------------------------------------------------------
	// reset stretch sequencer
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_HOLD,
		ST_COUNT,
		ST_RUN
	} sgrc_rst_state_t;

	sgrc_rst_state_t state;
	sgrc_rst_state_t next_state;
	logic [SGRC_CNT_W-1:0] tout_limit;
	logic cnt_done;
	wire cnt_clear = any_src || (state != ST_COUNT);

	// any new source forces hold, whichever state the sequencer is in
	always_comb begin
		next_state = state;
		case (state)
			ST_HOLD: begin
				if (!any_src) begin
					next_state = ST_COUNT;
				end
			end
			ST_COUNT: begin
				if (any_src) begin
					next_state = ST_HOLD;
				end else if (cnt_done) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (any_src) begin
					next_state = ST_HOLD;
				end
			end
			default: begin
				next_state = ST_HOLD;
			end
		endcase
	end

	wire next_core_rst = (next_state != ST_RUN);
	wire next_vector = (state == ST_COUNT) && (next_state == ST_RUN);
	// causes accumulate across releases until the block reset
	wire [SGRC_NUM_SRC-1:0] next_cause = (state == ST_RUN && !any_src) ?
		RESET_CAUSE_OUT : (RESET_CAUSE_OUT | src);

	sgrc_tout_sel #(
		.W(SGRC_CNT_W),
		.TOUT0(TOUT_CYC0),
		.TOUT1(TOUT_CYC1),
		.TOUT2(TOUT_CYC2),
		.TOUT3(TOUT_CYC3)
	) u_tout (
		.clk_in(CLOCK_IN),
		.sut_in(STARTUP_TIME_FUSES_IN),
		.clock_select_fuses_in(CLOCK_SELECT_FUSES_IN),
		.limit_out(tout_limit)
	);

	sgrc_delay_cnt #(
		.W(SGRC_CNT_W)
	) u_cnt (
		.clk_in(CLOCK_IN),
		.rst_in(RST_IN),
		.clear_in(cnt_clear),
		.limit_in(tout_limit),
		.done_out(cnt_done)
	);

	// ----------------------------------------------------------------
	// state and reset outputs
	// ----------------------------------------------------------------
	// reset cause cleared only by the block reset, like a status register
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			state <= ST_HOLD;
			CORE_RESET_OUT <= SGRC_CORE_RST_INIT;
			IO_REG_INIT_OUT <= SGRC_CORE_RST_INIT;
			START_AT_VECTOR_OUT <= 1'b0;
			RESET_CAUSE_OUT <= '0;
		end else begin
			state <= next_state;
			CORE_RESET_OUT <= next_core_rst;
			IO_REG_INIT_OUT <= next_core_rst;
			START_AT_VECTOR_OUT <= next_vector;
			RESET_CAUSE_OUT <= next_cause;
		end
	end

	// gating outputs, all registered
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			ADC_POWER_OUT <= 1'b0;
			ADC_EXTENDED_OUT <= 1'b0;
			ACMP_POWER_OUT <= 1'b0;
			VREF_POWER_OUT <= 1'b0;
			BOD_ACTIVE_OUT <= 1'b0;
			WDT_RUN_OUT <= 1'b0;
			INPUT_BUF_EN_OUT <= '1;
			MAIN_CLK_RUN_OUT <= 1'b1;
			SCAN_PORT_ACTIVE_OUT <= 1'b0;
			TDO_OUT <= 1'b0;
			TDO_OE_N_OUT <= 1'b1;
		end else begin
			ADC_POWER_OUT <= next_adc_power;
			ADC_EXTENDED_OUT <= next_adc_ext;
			ACMP_POWER_OUT <= next_acmp_power;
			VREF_POWER_OUT <= next_vref;
			BOD_ACTIVE_OUT <= bod_on;
			WDT_RUN_OUT <= next_wdt_run;
			INPUT_BUF_EN_OUT <= next_buf_en;
			MAIN_CLK_RUN_OUT <= next_main_clk;
			SCAN_PORT_ACTIVE_OUT <= scan_active;
			TDO_OUT <= next_tdo;
			TDO_OE_N_OUT <= next_tdo_oe_n;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (RST_IN);

	a_adc_stays_on: assert property (
		ADC_EN_IN && SLEEP_IN |=> ADC_POWER_OUT)
		else $error("converter dropped in sleep");

	a_adc_ext_flag: assert property (
		!ADC_POWER_OUT ##1 ADC_POWER_OUT |-> ADC_EXTENDED_OUT)
		else $error("extended conversion not flagged");

	a_acmp_deep_off: assert property (
		deep_sleep |=> !ACMP_POWER_OUT)
		else $error("comparator on in deep sleep");

	a_vref_needed: assert property (
		(bod_on || acmp_ref_need || ADC_EN_IN) |=> VREF_POWER_OUT)
		else $error("reference off while needed");

	a_vref_idle_off: assert property (
		!bod_on && !ACMP_EN_IN && !ADC_EN_IN |=> !VREF_POWER_OUT)
		else $error("reference on with no user");

	a_buf_gating: assert property (
		clocks_stopped |=> INPUT_BUF_EN_OUT == $past(WAKE_PIN_NEED_IN))
		else $error("input buffers not gated");

	a_main_clk_dbg: assert property (
		DEBUG_ENABLE_FUSE_IN && scan_active |=> MAIN_CLK_RUN_OUT)
		else $error("main clock stopped under debug");

	a_tdo_float: assert property (
		scan_active && !TAP_SHIFT_IN |=> TDO_OE_N_OUT)
		else $error("data-out driven while idle");

	a_src_holds_rst: assert property (
		any_src |=> CORE_RESET_OUT [*2])
		else $error("core left reset with source active");

	a_release_timing: assert property (
		state == ST_HOLD && !any_src ##1 !any_src [*2]
		|-> CORE_RESET_OUT)
		else $error("reset released with no stretch");

	a_vector_pulse: assert property (
		START_AT_VECTOR_OUT |-> !CORE_RESET_OUT ##1 !START_AT_VECTOR_OUT)
		else $error("vector start not a single pulse at release");

	a_bod_in_sleep: assert property (
		bod_on && SLEEP_IN |=> BOD_ACTIVE_OUT)
		else $error("brown-out detector off in sleep");

	a_wdt_in_sleep: assert property (
		WDT_EN_IN && SLEEP_IN |=> WDT_RUN_OUT)
		else $error("watchdog stopped in sleep");

	a_scan_off: assert property (
		!SCAN_PORT_ENABLE_FUSE_IN || SCAN_PORT_DISABLE_BIT_IN
		|=> !SCAN_PORT_ACTIVE_OUT && TDO_OE_N_OUT)
		else $error("scan port active while disabled");

	a_ext_rst_hold: assert property (
		!EXT_RST_N_IN |=> CORE_RESET_OUT && RESET_CAUSE_OUT.external)
		else $error("external reset not applied");

endmodule

// ### hdl/sgrc_pkg.sv
// package for the sleep gating and reset control block
// assumes one 10 MHz clock; reset sources arrive synchronous to it

package sgrc_pkg;

	// ----------------------------------------------------------------
	// sleep modes and reset sources
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SGRC_IDLE,
		SGRC_ADC_NR,
		SGRC_POWER_DOWN,
		SGRC_POWER_SAVE,
		SGRC_STANDBY
	} sgrc_sleep_mode_t;

	typedef struct packed {
		logic power_on;
		logic external;
		logic watchdog;
		logic brown_out;
		logic scan_reg;
	} sgrc_rst_src_t;

	// ----------------------------------------------------------------
	// widths, fuse codings and reset values
	// ----------------------------------------------------------------
	localparam int SGRC_NUM_SRC = 5;
	localparam logic [1:0] SGRC_BOD_OFF_CODE = 2'h3;
	localparam int SGRC_SUT_W = 2;
	localparam int SGRC_CLOCK_SELECT_FUSES_W = 4;
	localparam int SGRC_CLOCK_SELECT_FUSES_XTAL_BIT = 3;
	localparam int SGRC_XTAL_SHIFT = 2;
	localparam int SGRC_CNT_W = 20;
	localparam int SGRC_CNT_RST = 0;
	localparam logic SGRC_CORE_RST_INIT = 1'b1;

endpackage

// ### hdl/sgrc_delay_cnt.sv
// reset stretch counter: counts up to a limit after clear drops
// assumes clear is held while the reset request is active
`timescale 1ns/10ps

module sgrc_delay_cnt #(
	parameter int W = 20
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic clear_in,
	input wire logic [W-1:0] limit_in,
	output logic done_out
);
	import sgrc_pkg::*;

	logic [W-1:0] cnt;
	wire at_limit = (cnt == limit_in);

	// restart from zero on clear; done stays until the next clear
	always_ff @(posedge clk_in) begin
		if (rst_in || clear_in) begin
			cnt <= W'(SGRC_CNT_RST);
			done_out <= 1'b0;
		end else if (!done_out) begin
			if (at_limit) begin
				done_out <= 1'b1;
			end else begin
				cnt <= cnt + W'(1);
			end
		end
	end

endmodule

// ### hdl/sgrc_tout_sel.sv
// time-out length lookup from start-up and clock-select fuses
// assumes fuses are static; the result is registered
`timescale 1ns/10ps

module sgrc_tout_sel #(
	parameter int W = 20,
	parameter logic [W-1:0] TOUT0 = 20'h00010,
	parameter logic [W-1:0] TOUT1 = 20'h00080,
	parameter logic [W-1:0] TOUT2 = 20'h00400,
	parameter logic [W-1:0] TOUT3 = 20'h02000
) (
	input wire logic clk_in,
	input wire logic [sgrc_pkg::SGRC_SUT_W-1:0] sut_in,
	input wire logic [sgrc_pkg::SGRC_CLOCK_SELECT_FUSES_W-1:0] clock_select_fuses_in,
	output logic [W-1:0] limit_out
);
	import sgrc_pkg::*;

	wire [W-1:0] base = (sut_in == 2'h0) ? TOUT0 :
		(sut_in == 2'h1) ? TOUT1 :
		(sut_in == 2'h2) ? TOUT2 : TOUT3;
	// crystal sources get a longer settle; shift can wrap at huge bases
	wire xtal = clock_select_fuses_in[SGRC_CLOCK_SELECT_FUSES_XTAL_BIT];
	wire [W-1:0] next_limit = xtal ? (base << SGRC_XTAL_SHIFT) : base;

	// registered so the counter compare sees a clean value
	always_ff @(posedge clk_in) begin
		limit_out <= next_limit;
	end

endmodule

// ### dv/sgrc_core_model.sv
// core-side model: counts program starts, tracks reference readiness
// assumes one clock shared with the block, bench reset on rst_in
`timescale 1ns/10ps

module sgrc_core_model #(
	parameter int REF_WAIT = 3
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic core_rst_in,
	input wire logic start_in,
	input wire logic vref_in,
	output logic [7:0] starts_out,
	output logic ref_ready_out
);
	logic [3:0] ref_cnt;

	// one start per release; a start while held is ignored
	always_ff @(posedge clk_in) begin
		if (rst_in)
			starts_out <= 8'h00;
		else if (start_in && !core_rst_in)
			starts_out <= starts_out + 8'h01;
	end

	// software must not use the reference before it has settled
	always_ff @(posedge clk_in) begin
		if (rst_in || !vref_in)
			ref_cnt <= 4'h0;
		else if (ref_cnt < 4'(REF_WAIT))
			ref_cnt <= ref_cnt + 4'h1;
	end
	assign ref_ready_out = vref_in && (ref_cnt == 4'(REF_WAIT));
endmodule

// ### dv/sgrc_top_tb.sv
// bench for the sleep gating and reset control block
// assumes short time-outs of 4..7 cycles set through parameters, and 20 with the crystal fuse bit set
`timescale 1ns/10ps

module sgrc_top_tb;
	import sgrc_pkg::*;
	logic clk, rst, slp, adc, conv, acm, aref, wen, wex, dbg, sfu, sdis;
	logic sh, tdi, por, extn, bdet, srr, mco, tdo, toe, prst, crst, ioi;
	logic stv, adp, ext, acp, vrp, bda, wrn, spa, rdy;
	logic [1:0] bfu, startup_time_fuses;
	logic [3:0] cks;
	logic [7:0] wake, ibuf, starts;
	sgrc_sleep_mode_t mode;
	sgrc_rst_src_t cause;
	int mismatches;
	int samples_checked;

	sgrc_top #(.TOUT_CYC0(20'h00004), .TOUT_CYC1(20'h00005),
		.TOUT_CYC2(20'h00006), .TOUT_CYC3(20'h00007)) u_sgrc_top (
		.CLOCK_IN(clk), .RST_IN(rst), .SLEEP_IN(slp), .SLEEP_MODE_IN(mode),
		.ADC_EN_IN(adc), .CONV_START_IN(conv), .ACMP_EN_IN(acm),
		.ACMP_USE_REF_IN(aref), .BROWN_OUT_LEVEL_FUSES_IN(bfu),
		.WDT_EN_IN(wen), .WDT_EXPIRE_IN(wex), .WAKE_PIN_NEED_IN(wake),
		.DEBUG_ENABLE_FUSE_IN(dbg), .SCAN_PORT_ENABLE_FUSE_IN(sfu),
		.SCAN_PORT_DISABLE_BIT_IN(sdis), .TAP_SHIFT_IN(sh),
		.TDO_DATA_IN(tdi), .POWER_ON_RST_IN(por), .EXT_RST_N_IN(extn),
		.BROWN_OUT_DET_IN(bdet), .SCAN_RST_REG_IN(srr),
		.STARTUP_TIME_FUSES_IN(startup_time_fuses), .CLOCK_SELECT_FUSES_IN(cks),
		.ADC_POWER_OUT(adp), .ADC_EXTENDED_OUT(ext), .ACMP_POWER_OUT(acp),
		.VREF_POWER_OUT(vrp), .BOD_ACTIVE_OUT(bda), .WDT_RUN_OUT(wrn),
		.INPUT_BUF_EN_OUT(ibuf), .MAIN_CLK_RUN_OUT(mco),
		.SCAN_PORT_ACTIVE_OUT(spa), .TDO_OUT(tdo), .TDO_OE_N_OUT(toe),
		.PORT_RESET_OUT(prst), .CORE_RESET_OUT(crst),
		.IO_REG_INIT_OUT(ioi), .START_AT_VECTOR_OUT(stv),
		.RESET_CAUSE_OUT(cause));

	sgrc_core_model u_sgrc_core_model (.clk_in(clk),
		.rst_in(rst), .core_rst_in(crst), .start_in(stv), .vref_in(vrp),
		.starts_out(starts), .ref_ready_out(rdy));

	// ----------------------------------------------------------------
	// clock, watchdog and shared tasks
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// whole run is under two hundred cycles; 2000 is ample
	initial begin
		#200000;
		mismatches++;
		end_of_test();
	end

	task automatic tick();
		@(posedge clk);
		#10;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// caller has just dropped the last source; next edge is E0
	task automatic rel(input int l);
		tick();
		repeat (l + 1) tick();
		chk(crst, 1'b1);
		tick();
		chk({crst, ioi, stv}, 3'b001);
		tick();
		chk(stv, 1'b0);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_sleep();
		adc = 1'b1; acm = 1'b1; bfu = 2'h2; wen = 1'b1; wake = 8'h05;
		slp = 1'b1; mode = SGRC_POWER_DOWN;
		tick(); tick();
		chk({adp, acp, bda, wrn, vrp}, 5'b10111);
		chk(ibuf, 8'h05);
		chk(mco, 1'b0);
		dbg = 1'b1; sfu = 1'b1; mode = SGRC_POWER_SAVE;
		tick(); tick();
		chk(mco, 1'b1);
		mode = SGRC_IDLE;
		tick();
		chk({acp, ibuf}, 9'h1ff);
		adc = 1'b0; bfu = 2'h3; aref = 1'b1; mode = SGRC_STANDBY;
		tick(); tick();
		chk({acp, vrp}, 2'b01);
		repeat (3) tick();
		chk(rdy, 1'b1);
		acm = 1'b0;
		tick(); tick();
		chk(vrp, 1'b0);
		slp = 1'b0; dbg = 1'b0; wen = 1'b0;
	endtask

	task automatic t_adc();
		adc = 1'b1;
		tick(); tick();
		chk({adp, ext}, 2'b11);
		conv = 1'b1;
		tick();
		conv = 1'b0;
		tick();
		chk(ext, 1'b0);
		adc = 1'b0;
		tick(); tick();
		adc = 1'b1;
		tick(); tick();
		chk(ext, 1'b1);
	endtask

	task automatic t_scan();
		sh = 1'b0; tdi = 1'b1;
		tick(); tick();
		chk({spa, toe}, 2'b11);
		sh = 1'b1;
		tick(); tick();
		chk({toe, tdo}, 2'b01);
		sdis = 1'b1;
		tick(); tick();
		chk({spa, toe}, 2'b01);
		sdis = 1'b0; sfu = 1'b0;
		tick(); tick();
		chk(spa, 1'b0);
		sh = 1'b0;
	endtask

	task automatic t_reset();
		// expiry with the watchdog disabled must not reset anything
		wex = 1'b1;
		tick(); tick();
		chk({crst, prst}, 2'b00);
		wex = 1'b0;
		extn = 1'b0;
		#1 chk(prst, 1'b1);
		tick();
		chk({crst, ioi}, 2'b11);
		extn = 1'b1;
		rel(4);
		extn = 1'b0;
		tick();
		extn = 1'b1;
		repeat (3) tick();
		wen = 1'b1; wex = 1'b1;
		tick();
		wex = 1'b0;
		rel(4);
		bfu = 2'h2; bdet = 1'b1;
		tick();
		bdet = 1'b0;
		rel(4);
		srr = 1'b1;
		repeat (5) tick();
		chk(crst, 1'b1);
		srr = 1'b0;
		startup_time_fuses = 2'h1; cks = 4'h8;
		rel(20);
		por = 1'b1;
		tick();
		por = 1'b0;
		rel(20);
		chk(cause, 5'h1f);
		chk(starts, 8'h06);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1; slp = 1'b0; mode = SGRC_IDLE; adc = 1'b0; conv = 1'b0;
		acm = 1'b0; aref = 1'b0; bfu = 2'h3; wen = 1'b0; wex = 1'b0;
		wake = 8'h00; dbg = 1'b0; sfu = 1'b0; sdis = 1'b0; sh = 1'b0;
		tdi = 1'b0; por = 1'b0; extn = 1'b1; bdet = 1'b0; srr = 1'b0;
		startup_time_fuses = 2'h0; cks = 4'h0; mismatches = 0; samples_checked = 0;
		repeat (6) tick();
		rst = 1'b0;
		for (int i = 0; i < 50 && crst !== 1'b0; i++)
			tick();
		chk(crst, 1'b0);
		t_sleep();
		t_adc();
		t_scan();
		t_reset();
		end_of_test();
	end
endmodule
